// File: design/pulser_direct_mode_control.v
// Purpose: direct-mode control of an eight-channel ultrasound pulser
// Assumes: ref_clk is the master clock; inputs synchronous to it
// Notes: thermal sensor supplies a temperature code in whole degrees
//
// Behaviour
// - 3-level pair decode selects rail, clamp, damp
// - Eight independent channels, beamforming held off
// - Transmitter and switches follow logic inputs
// - 5-level pairs channel n with n+4
// - In 5-level, high channels never close receive switch
// - 5-level transmits only with valid supply order
// - Both low: return-zero picks clamp or Hi-Z
// - Single input drives rail, select picks A/B
// - Transparent mode follows inputs directly
// - Clocked mode registers inputs on clock edge
// - Sync input picks transparent or clocked
// - Two-bit current code for all channels
// - Beamforming current and low-drop from registers
// - Low-drop only in beamforming mode
// - Warning above 110, release below 105
// - Shutdown above 150, release below 130
// - Beamforming logs thermal events in thermal log register
// - Mode input selects four operating modes
`include "pulser_direct_defs.vh"

module pulser_direct_mode_control #(
  parameter NUM_CH = 8
) (
  ref_clk,
  reset,
  op_select_lo,
  op_select_hi,
  sync_clocked,
  neg_drive_in,
  pos_drive_in,
  drive_current_code_hi,
  drive_current_code_lo,
  supply_order_ok,
  junction_temp,
  high_voltage_output,
  damp_enable,
  receive_switch_output,
  drive_current_code,
  low_drop_enable,
  beamform_enable,
  thermal_warning_out,
  thermal_warning_oe,
  thermal_shutdown,
  avs_address,
  avs_read,
  avs_write,
  avs_writedata,
  avs_readdata,
  avs_waitrequest
);
  input wire ref_clk;
  input wire reset;
  input wire op_select_lo;
  input wire op_select_hi;
  input wire sync_clocked;
  input wire [NUM_CH-1:0] neg_drive_in;
  input wire [NUM_CH-1:0] pos_drive_in;
  input wire drive_current_code_hi;
  input wire drive_current_code_lo;
  input wire supply_order_ok;
  input wire [7:0] junction_temp;
  output reg [3*NUM_CH-1:0] high_voltage_output;
  output reg [NUM_CH-1:0] damp_enable;
  output reg [NUM_CH-1:0] receive_switch_output;
  output reg [1:0] drive_current_code;
  output reg low_drop_enable;
  output reg beamform_enable;
  output reg thermal_warning_out;
  output reg thermal_warning_oe;
  output reg thermal_shutdown;
  input wire [3:0] avs_address;
  input wire avs_read;
  input wire avs_write;
  input wire [31:0] avs_writedata;
  output reg [31:0] avs_readdata;
  output reg avs_waitrequest;

  localparam HALF = NUM_CH / 2;

  wire [1:0] op_mode;
  reg [NUM_CH-1:0] neg_cap_q;
  reg [NUM_CH-1:0] pos_cap_q;
  wire [NUM_CH-1:0] neg_use;
  wire [NUM_CH-1:0] pos_use;
  reg warn_q;
  reg shut_q;
  reg [31:0] ctrl_q;
  reg [1:0] therm_log_q;
  reg ack_q;
  wire tx_enable;
  wire [3*NUM_CH-1:0] hv_d;
  wire [NUM_CH-1:0] damp_d;
  wire [NUM_CH-1:0] tr_d;
  reg [1:0] cc_d;
  wire [1:0] log_set;
  wire log_clear;

  assign op_mode = {op_select_hi, op_select_lo};

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      neg_cap_q <= {NUM_CH{1'b0}};
      pos_cap_q <= {NUM_CH{1'b0}};
    end else begin
      neg_cap_q <= neg_drive_in;
      pos_cap_q <= pos_drive_in;
    end
  end

  assign neg_use = sync_clocked ? neg_cap_q : neg_drive_in;
  assign pos_use = sync_clocked ? pos_cap_q : pos_drive_in;

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      warn_q <= 1'b0;
      shut_q <= 1'b0;
    end else begin
      if (junction_temp > `T_WARN_ON)
        warn_q <= 1'b1;
      else if (junction_temp < `T_WARN_OFF)
        warn_q <= 1'b0;
      if (junction_temp > `T_SHUT_ON)
        shut_q <= 1'b1;
      else if (junction_temp < `T_SHUT_OFF)
        shut_q <= 1'b0;
    end
  end

  assign tx_enable = !shut_q && (op_mode == `OP_DIRECT3 ||
    (op_mode == `OP_DIRECT5 && supply_order_ok));

  // One decoder per channel, pairs n and n+HALF
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1) begin : ch
      localparam LO = (g < HALF) ? g : g - HALF;
      localparam HI = LO + HALF;
      wire n5;
      wire p5;
      assign n5 = (op_mode == `OP_DIRECT5) ? neg_use[LO] : neg_use[g];
      assign p5 = (op_mode == `OP_DIRECT5) ? pos_use[LO] : pos_use[g];
      pulser_channel_decode dec (
        .op_mode(op_mode),
        .tx_enable(tx_enable),
        .is_high_chan(g >= HALF),
        .neg_in(n5),
        .pos_in(p5),
        .sel_in(neg_use[HI]),
        .rtz_in(pos_use[HI]),
        .hv_state(hv_d[3*g+2:3*g]),
        .damp_on(damp_d[g]),
        .tr_on(tr_d[g])
      );
    end
  endgenerate

  always @* begin
    if (op_mode == `OP_BEAMFORM)
      cc_d = {ctrl_q[`CTRL_CC_HI], ctrl_q[`CTRL_CC_LO]};
    else
      cc_d = {drive_current_code_hi, drive_current_code_lo};
  end

  // Registered outputs; adds one cycle of latency on every path
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      high_voltage_output <= {3*NUM_CH{1'b0}};
      damp_enable <= {NUM_CH{1'b0}};
      receive_switch_output <= {NUM_CH{1'b0}};
      drive_current_code <= 2'h0;
      low_drop_enable <= 1'b0;
      beamform_enable <= 1'b0;
      thermal_warning_out <= 1'b0;
      thermal_warning_oe <= 1'b0;
      thermal_shutdown <= 1'b0;
    end else begin
      high_voltage_output <= hv_d;
      damp_enable <= damp_d;
      receive_switch_output <= tr_d;
      drive_current_code <= cc_d;
      low_drop_enable <= (op_mode == `OP_BEAMFORM) &&
        ctrl_q[`CTRL_LOW_DROP] && !shut_q;
      // Beamforming held off in direct modes
      beamform_enable <= (op_mode == `OP_BEAMFORM) && !shut_q;
      // Open drain: pull low while warning
      thermal_warning_out <= 1'b0;
      thermal_warning_oe <= warn_q;
      thermal_shutdown <= shut_q;
    end
  end

  // Sticky log, set wins over clear
  assign log_set = (op_mode == `OP_BEAMFORM) ? {shut_q, warn_q} : 2'h0;
  assign log_clear = avs_write && !ack_q && avs_address == `REG_THERM_LOG;

  // Register slave: one wait cycle, then answer
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= `CTRL_RESET;
      therm_log_q <= 2'h0;
      ack_q <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
    end else begin
      therm_log_q <= (therm_log_q &
        ~(log_clear ? avs_writedata[1:0] : 2'h0)) | log_set;
      if ((avs_read || avs_write) && !ack_q) begin
        ack_q <= 1'b1;
        avs_waitrequest <= 1'b0;
        if (avs_write && avs_address == `REG_CTRL)
          ctrl_q <= {29'h0000_0000, avs_writedata[2:0]};
        case (avs_address)
          `REG_CTRL: avs_readdata <= ctrl_q;
          `REG_STATUS: avs_readdata <= {24'h00_0000, supply_order_ok,
            op_mode, tx_enable, beamform_enable, shut_q, warn_q, 1'b0};
          `REG_THERM_LOG: avs_readdata <= {30'h0000_0000, therm_log_q};
          `REG_TEMP: avs_readdata <= {24'h00_0000, junction_temp};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end else begin
        ack_q <= 1'b0;
        avs_waitrequest <= 1'b1;
      end
    end
  end
endmodule

// File: design/pulser_direct_defs.vh
// Purpose: shared constants for the pulser direct-mode controller
// Assumes: 40 MHz ref_clk, Avalon-MM register slave with 32-bit data
// Notes: offsets are byte addresses
`ifndef PULSER_DIRECT_DEFS_VH
`define PULSER_DIRECT_DEFS_VH

`define OP_SHUTDOWN 2'h0
`define OP_DIRECT3 2'h1
`define OP_DIRECT5 2'h2
`define OP_BEAMFORM 2'h3

// Output stage encodings
`define HV_HIZ 3'h0
`define HV_CLAMP 3'h1
`define HV_POS_A 3'h2
`define HV_NEG_A 3'h3
`define HV_POS_B 3'h4
`define HV_NEG_B 3'h5

// Register offsets
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_THERM_LOG 4'h8
`define REG_TEMP 4'hC

// Control field positions
`define CTRL_CC_LO 0
`define CTRL_CC_HI 1
`define CTRL_LOW_DROP 2
`define CTRL_RESET 32'h0000_0000

// Temperature thresholds, whole degrees C
`define T_WARN_ON 8'h6E
`define T_WARN_OFF 8'h69
`define T_SHUT_ON 8'h96
`define T_SHUT_OFF 8'h82

`endif

// File: design/pulser_channel_decode.v
// Purpose: decode one channel's drive inputs into output stage state
// Assumes: inputs already captured or transparent as chosen upstream
// Notes: purely combinational; the top registers its outputs
`include "pulser_direct_defs.vh"

module pulser_channel_decode (
  op_mode,
  tx_enable,
  is_high_chan,
  neg_in,
  pos_in,
  sel_in,
  rtz_in,
  hv_state,
  damp_on,
  tr_on
);
  input wire [1:0] op_mode;
  input wire tx_enable;
  input wire is_high_chan;
  input wire neg_in;
  input wire pos_in;
  input wire sel_in;
  input wire rtz_in;
  output reg [2:0] hv_state;
  output reg damp_on;
  output reg tr_on;

  always @* begin
    hv_state = `HV_HIZ;
    damp_on = 1'b0;
    tr_on = 1'b0;
    if (!tx_enable) begin
      hv_state = `HV_HIZ;
    end else if (op_mode == `OP_DIRECT3) begin
      case ({neg_in, pos_in})
        2'h0: hv_state = `HV_CLAMP;
        2'h2: hv_state = `HV_NEG_A;
        2'h1: hv_state = `HV_POS_A;
        default: begin
          hv_state = `HV_CLAMP;
          damp_on = 1'b1;
          tr_on = 1'b1;
        end
      endcase
    end else if (op_mode == `OP_DIRECT5) begin
      case ({neg_in, pos_in})
        2'h0: hv_state = rtz_in ? `HV_CLAMP : `HV_HIZ;
        2'h1: hv_state = sel_in ? `HV_POS_B : `HV_POS_A;
        2'h2: hv_state = sel_in ? `HV_NEG_B : `HV_NEG_A;
        default: begin
          hv_state = `HV_CLAMP;
          damp_on = 1'b1;
          tr_on = ~is_high_chan;
        end
      endcase
    end
  end
endmodule

// File: tb/pdmc_properties.sv
// Purpose: port checks for the pulser direct-mode controller
// Assumes: one ref_clk domain, reset async high
// Notes: three to four edges cover capture plus output register
module pdmc_props #(parameter NUM_CH = 8) (
  input ref_clk,
  input reset,
  input op_select_lo,
  input op_select_hi,
  input [7:0] junction_temp,
  input [3*NUM_CH-1:0] high_voltage_output,
  input [NUM_CH-1:0] damp_enable,
  input [NUM_CH-1:0] receive_switch_output,
  input low_drop_enable,
  input thermal_warning_oe,
  input thermal_shutdown
);
  wire d3 = op_select_lo & ~op_select_hi;
  wire d5 = op_select_hi & ~op_select_lo;
  wire bf = op_select_hi & op_select_lo;
  wire hot = junction_temp > 8'h96;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  a_shut_hiz:
    assert property ((!(d3 | d5 | bf) | hot)[*4] |->
      !(|{high_voltage_output, receive_switch_output})) else $error("hv on");
  a_hi_tr_off:
    assert property (d5[*3] |->
      !(|receive_switch_output[NUM_CH-1:NUM_CH/2])) else $error("tr hi");
  a_tr_damp:
    assert property (d3[*3] |-> receive_switch_output == damp_enable)
    else $error("tr damp");
  a_low_drop:
    assert property ((!bf)[*3] |-> !low_drop_enable) else $error("drop");
  a_warn_set:
    assert property ((junction_temp > 8'h6E)[*3] |-> thermal_warning_oe)
    else $error("warn set");
  a_warn_clr:
    assert property ((junction_temp < 8'h69)[*3] |-> !thermal_warning_oe)
    else $error("warn clr");
  a_shut_set:
    assert property (hot[*3] |-> thermal_shutdown) else $error("shut set");
  a_shut_clr:
    assert property ((junction_temp < 8'h82)[*3] |-> !thermal_shutdown)
    else $error("shut clr");
  c_tr_on: cover property (d5 && receive_switch_output[0]);
  c_shut: cover property (thermal_shutdown);
  c_drop: cover property (low_drop_enable);
endmodule

bind pulser_direct_mode_control pdmc_props #(.NUM_CH(NUM_CH)) props_inst (.*);

// File: tb/fpga_driver.sv
// Purpose: far-side logic source for the channel input pins
// Assumes: pins change just after a rising ref_clk edge
// Notes: every pattern is preceded by an all-low hold
module fpga_driver (
  input ref_clk,
  output logic [7:0] neg_drive_in,
  output logic [7:0] pos_drive_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {neg_drive_in, pos_drive_in} = 16'h0000;
  // switch open lead
  // 32 cycles of 25 ns, the minimum transmit setup
  task automatic send(logic [7:0] n, logic [7:0] p);
    @(posedge ref_clk);
    {neg_drive_in, pos_drive_in} <= 16'h0000;
    repeat (32) @(posedge ref_clk);
    {neg_drive_in, pos_drive_in} <= {n, p};
  endtask
endmodule

// File: tb/testbench.sv
// Purpose: self-checking bench for the pulser controller
// Assumes: 40 MHz clock, partner drives channel pins
// Notes: model decodes each channel from integers
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, reset, op_select_lo, op_select_hi, sync_clocked;
  logic drive_current_code_hi, drive_current_code_lo, supply_order_ok;
  logic [7:0] junction_temp, neg_drive_in, pos_drive_in, t[7];
  logic [7:0] damp_enable, receive_switch_output;
  logic [23:0] high_voltage_output;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_address;
  logic [1:0] drive_current_code;
  logic avs_read, avs_write, avs_waitrequest, low_drop_enable;
  logic beamform_enable, thermal_warning_out, thermal_warning_oe;
  logic thermal_shutdown;
  logic [4:0] s;
  wire [1:0] cc_pins = {drive_current_code_hi, drive_current_code_lo};
  int failures, n_compared, m, wn, sh, i;
  pulser_direct_mode_control pulser_direct_mode_control_inst (.*);
  fpga_driver fpga_driver_inst (.*);
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task chk(string nm, logic [31:0] seen, logic [31:0] ex);
    n_compared++;
    if (seen !== ex) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task end_of_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task bus(bit w, logic [3:0] a, logic [31:0] d);
    @(posedge ref_clk);
    {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, d};
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      failures++;
      end_of_test;
    end
    q = avs_readdata;
    {avs_write, avs_read} <= 2'h0;
  endtask
  // Result packs hv state, damp, receive switch
  function automatic logic [4:0] dec(int g, logic [7:0] n, logic [7:0] p);
    int l;
    l = m == 2 ? g % 4 : g;
    if (m % 3 == 0 || sh || (m == 2 && !supply_order_ok)) return 5'h00;
    if (n[l] && p[l]) return (g < 4 || m == 1) ? 5'h07 : 5'h06;
    if (!n[l] && !p[l]) return (m == 2 && !p[l + 4]) ? 5'h00 : 5'h04;
    return {3'((p[l] ? 2 : 3) + (m == 2 && n[l + 4] ? 2 : 0)), 2'h0};
  endfunction
  task check_out(logic [7:0] n, logic [7:0] p);
    for (int g = 0; g < 8; g++) begin
      s = {high_voltage_output[3*g +: 3], damp_enable[g],
        receive_switch_output[g]};
      chk("channel", s, dec(g, n, p));
    end
    chk("beamform", beamform_enable, m == 3 && !sh);
    chk("low drop", low_drop_enable, m == 3 && !sh);
    chk("warn pin", thermal_warning_out, 1'b0);
    chk("shutdown", thermal_shutdown, sh);
    chk("warning", thermal_warning_oe, wn);
    if (m != 0) chk("current", drive_current_code, m == 3 ? 2'h3 : cc_pins);
  endtask
  // Clocked capture shows the all-low hold one edge longer
  task apply(logic [7:0] n, logic [7:0] p);
    fpga_driver_inst.send(n, p);
    @(posedge ref_clk);
    #1;
    check_out(sync_clocked ? 8'h00 : n, sync_clocked ? 8'h00 : p);
    @(posedge ref_clk);
    #1;
    check_out(n, p);
  endtask
  initial begin
    {op_select_lo, op_select_hi, sync_clocked, supply_order_ok} = 4'h0;
    {drive_current_code_hi, drive_current_code_lo} = 2'h0;
    {avs_write, avs_read, avs_address, avs_writedata} = 38'h0;
    junction_temp = 8'h19;
    t = '{8'h78, 8'h6C, 8'h64, 8'hA0, 8'h8C, 8'h78, 8'h19};
    reset = 1'b1;
    void'($urandom(68));
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    bus(0, 4'h0, 32'h0);
    chk("ctrl reset", q, 32'h0);
    bus(1, 4'h0, 32'hFFFF_FFFF);
    bus(0, 4'h0, 32'h0);
    chk("ctrl", q, 32'h7);
    bus(0, 4'h6, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("registers done");
    m = 1;
    foreach (t[j]) begin
      if (t[j] > 110) wn = 1;
      else if (t[j] < 105) wn = 0;
      if (t[j] > 150) sh = 1;
      else if (t[j] < 130) sh = 0;
      @(posedge ref_clk);
      {op_select_hi, op_select_lo, junction_temp} <= {2'h1, t[j]};
      apply(8'hF0, 8'h3C);
    end
    $display("thermal done");
    for (int k = 0; k < 48; k++) begin
      m = k % 4;
      @(posedge ref_clk);
      {op_select_hi, op_select_lo} <= m[1:0];
      {sync_clocked, drive_current_code_hi, drive_current_code_lo}
        <= 3'($urandom);
      supply_order_ok <= k % 8 != 6;
      apply(8'($urandom), 8'($urandom));
    end
    $display("decode done");
    @(posedge ref_clk);
    {op_select_hi, op_select_lo, junction_temp} <= {2'h3, 8'hA0};
    m = 3;
    wn = 1;
    sh = 1;
    apply(8'h00, 8'h00);
    bus(0, 4'h8, 32'h0);
    chk("log", q, 32'h3);
    bus(0, 4'h4, 32'h0);
    chk("status", q, {supply_order_ok, 7'h66});
    @(posedge ref_clk);
    junction_temp <= 8'h19;
    wn = 0;
    sh = 0;
    apply(8'h00, 8'h00);
    bus(1, 4'h8, 32'h3);
    bus(0, 4'h8, 32'h0);
    chk("log clear", q, 32'h0);
    $display("log done");
    end_of_test;
  end
endmodule
